//--- hdl/seg_lcd_ctrl.sv
`timescale 1ns/1ps
module seg_lcd_ctrl (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Control one fields.
    input  wire logic                          frame_clock_source_select_i,
    input  wire logic                          standby_run_enable_i,
    input  wire logic                          drive_source_select_i,
    input  wire logic [2:0]                    display_mode_field_i,
    input  wire logic [2:0]                    frame_rate_select_i,
    // Control two fields.
    input  wire logic                          divider_value_select_i,
    input  wire logic                          eight_common_bias_select_i,
    input  wire logic                          invert_display_i,
    input  wire logic                          blank_display_i,
    input  wire logic                          frame_irq_enable_i,
    input  wire logic                          frame_irq_clear_i,
    // Pin enable and blink configuration.
    input  wire logic [7:0]                    lcd_pin_enable_one_i,
    input  wire logic [seg_lcd_pkg::NUM_COM-1:0] com_pin_enable_i,
    input  wire logic [seg_lcd_pkg::NUM_SEG-1:0] seg_pin_enable_i,
    input  wire logic [seg_lcd_pkg::NUM_SEG-1:0] blink_enable_i,
    // Clock sources and standby.
    input  wire logic                          timebase_tick_i,
    input  wire logic                          watch_tick_i,
    input  wire logic                          standby_req_i,
    input  wire logic                          standby_type_bit_i,
    // Display memory write port.
    input  wire logic                          ram_we_i,
    input  wire logic [4:0]                    ram_addr_i,
    input  wire logic [7:0]                    ram_wdata_i,
    // Panel drive.
    output logic [seg_lcd_pkg::NUM_COM-1:0]    com_level_o,
    output logic [seg_lcd_pkg::NUM_COM-1:0]    com_select_o,
    output logic [seg_lcd_pkg::NUM_SEG-1:0]    seg_level_o,
    output logic                               polarity_o,
    output logic [seg_lcd_pkg::NUM_COM-1:0]    com_lcd_func_o,
    output logic [seg_lcd_pkg::NUM_SEG-1:0]    seg_lcd_func_o,
    output logic [3:0]                         vpin_lcd_func_o,
    output logic                               port_input_enable_o,
    output logic                               res_chain_on_o,
    output logic                               res_high_value_o,
    output logic [1:0]                         bias_code_o,
    output logic [3:0]                         duty_o,
    output logic                               frame_irq_flag_o,
    output logic                               frame_irq_o,
    output logic                               running_o
);
    import seg_lcd_pkg::*;

    // ---------------------------------------------------------------
    // State.
    // ---------------------------------------------------------------
    typedef enum { ST_HALT, ST_SCAN } mode_e;

    typedef struct packed {
        mode_e                  st;
        logic [2:0]             com_idx;
        logic                   pol;
        logic [BLINK_W+2:0]     blink_cnt;
        logic                   blink_on;
        logic [NUM_COM-1:0]     com_level;
        logic [NUM_COM-1:0]     com_select;
        logic [NUM_SEG-1:0]     seg_level;
        logic                   polarity;
        logic [NUM_COM-1:0]     com_func;
        logic [NUM_SEG-1:0]     seg_func;
        logic [3:0]             vpin_func;
        logic                   port_in;
        logic                   res_on;
        logic                   res_hi;
        logic [1:0]             bias;
        logic [3:0]             duty;
        logic                   irq_flag;
        logic                   irq;
        logic                   running;
    } state_s;

    state_s cur, nxt;
    logic [7:0] ram [RAM_BYTES];
    logic       src_tb, src_wt, stby_req, stby_type;
    logic       src_sel, slot_tick, run_ok;
    logic       four_com, last_slot;
    logic [3:0] duty_now;
    logic [NUM_SEG-1:0] seg_pat;

    // ---------------------------------------------------------------
    // Input synchronisers and frame rate generator.
    // ---------------------------------------------------------------
    seg_lcd_sync u_sync_tb (.clk_i(clk_i), .rst_i(rst_i),
        .d_i(timebase_tick_i), .q_o(src_tb));
    seg_lcd_sync u_sync_wt (.clk_i(clk_i), .rst_i(rst_i),
        .d_i(watch_tick_i), .q_o(src_wt));
    seg_lcd_sync u_sync_sr (.clk_i(clk_i), .rst_i(rst_i),
        .d_i(standby_req_i), .q_o(stby_req));
    seg_lcd_sync u_sync_st (.clk_i(clk_i), .rst_i(rst_i),
        .d_i(standby_type_bit_i), .q_o(stby_type));

    assign src_sel = frame_clock_source_select_i ? src_wt : src_tb;

    // Halt in standby of stop/watch type unless standby run is enabled.
    assign run_ok = (display_mode_field_i != MODE_OFF)
        && !(stby_req && stby_type && !standby_run_enable_i);

    seg_lcd_tick #(.W(PRESCALE_W), .BASE(TAP_BASE)) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .src_i  (src_sel),
        .run_i  (run_ok),
        .sel_i  (frame_rate_select_i),
        .tick_o (slot_tick)
    );

    // ---------------------------------------------------------------
    // Display memory: bytes 0..27 in eight-common mode, nibble pairs
    // 0..15 in four-common mode.
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (ram_we_i && (int'(ram_addr_i) < RAM_BYTES)) begin
            ram[ram_addr_i] <= ram_wdata_i;
        end
    end

    // ---------------------------------------------------------------
    // Mode decode and segment pattern fetch.
    // ---------------------------------------------------------------
    always_comb begin
        four_com = (display_mode_field_i == MODE_4C_D2)
            || (display_mode_field_i == MODE_4C_D3)
            || (display_mode_field_i == MODE_4C_D4);
        case (display_mode_field_i)
            MODE_4C_D2: duty_now = DUTY_2;
            MODE_4C_D3: duty_now = DUTY_3;
            MODE_4C_D4: duty_now = DUTY_4;
            default:    duty_now = DUTY_8;
        endcase
        // A shorter duty chosen mid-frame wraps at once instead of
        // walking the index through commons that the mode does not use.
        last_slot = ({1'b0, cur.com_idx} >= duty_now - 4'h1);
    end

    // Fetch is read straight from memory each slot, so writes appear at
    // the next fetch without a shadow copy.
    always_comb begin
        seg_pat = '0;
        for (int s = 0; s < NUM_SEG; s++) begin
            if (four_com) begin
                seg_pat[s] = ram[s/2][(s%2)*4 + int'(cur.com_idx[1:0])];
            end else if (s < SEG_8COM) begin
                seg_pat[s] = ram[s][cur.com_idx];
            end
        end
    end

    // ---------------------------------------------------------------
    // Scan sequencer.
    // ---------------------------------------------------------------
    always_comb begin
        nxt = cur;
        nxt.res_on = drive_source_select_i;
        nxt.res_hi = divider_value_select_i;
        nxt.duty = duty_now;
        nxt.port_in = lcd_pin_enable_one_i[PE_PORT_IN];
        if (four_com) begin
            nxt.bias = (duty_now == DUTY_2) ? 2'h2 : 2'h3;
        end else begin
            nxt.bias = eight_common_bias_select_i ? 2'h0 : 2'h3;
        end
        for (int c = 0; c < NUM_COM; c++) begin
            nxt.com_func[c] = com_pin_enable_i[c]
                && !(four_com && c >= 4);
        end
        for (int s = 0; s < NUM_SEG; s++) begin
            nxt.seg_func[s] = seg_pin_enable_i[s]
                && (four_com || s < SEG_8COM);
        end
        nxt.vpin_func = lcd_pin_enable_one_i[PE_VE4:PE_VE1];
        if (drive_source_select_i) begin
            nxt.vpin_func[3] = 1'b1;
        end
        if (frame_irq_clear_i) begin
            nxt.irq_flag = 1'b0;
        end
        case (cur.st)
            ST_HALT: begin
                nxt.com_idx = '0;
                nxt.running = 1'b0;
                nxt.com_select = '0;
                nxt.seg_level = '0;
                nxt.com_level = '0;
                if (run_ok) begin
                    nxt.st = ST_SCAN;
                    nxt.running = 1'b1;
                end
            end
            ST_SCAN: begin
                if (!run_ok) begin
                    nxt.st = ST_HALT;
                end else if (slot_tick) begin
                    nxt.com_select = '0;
                    nxt.com_select[cur.com_idx] = 1'b1;
                    // The selected common sits opposite a lit segment.
                    nxt.com_level = nxt.com_select ^ {NUM_COM{~cur.pol}};
                    if (blank_display_i) begin
                        nxt.seg_level = '0;
                    end else begin
                        nxt.seg_level = invert_display_i ? ~seg_pat
                            : seg_pat;
                        if (!cur.blink_on) begin
                            nxt.seg_level = nxt.seg_level & ~blink_enable_i;
                        end
                    end
                    nxt.seg_level = nxt.seg_level ^ {NUM_SEG{cur.pol}};
                    nxt.polarity = cur.pol;
                    if (last_slot) begin
                        nxt.com_idx = '0;
                        nxt.pol = ~cur.pol;
                        nxt.blink_cnt = cur.blink_cnt + 1'b1;
                        if (cur.blink_cnt[BLINK_W+1:0] == '1
                            && (lcd_pin_enable_one_i[PE_BLSEL]
                                || cur.blink_cnt[BLINK_W+2])) begin
                            nxt.blink_on = ~cur.blink_on;
                        end
                        if (frame_irq_enable_i) begin
                            nxt.irq_flag = 1'b1;
                        end
                    end else begin
                        nxt.com_idx = cur.com_idx + 3'h1;
                    end
                end
            end
            default: nxt.st = ST_HALT;
        endcase
        nxt.irq = nxt.irq_flag && frame_irq_enable_i;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur <= '0;
            cur.st <= ST_HALT;
            cur.blink_on <= 1'b1;
            cur.vpin_func <= PIN_EN_RESET[PE_VE4:PE_VE1];
            cur.bias <= 2'h3;
            cur.duty <= DUTY_8;
        end else begin
            cur <= nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs.
    // ---------------------------------------------------------------
    assign com_level_o = cur.com_level;
    assign com_select_o = cur.com_select;
    assign seg_level_o = cur.seg_level;
    assign polarity_o = cur.polarity;
    assign com_lcd_func_o = cur.com_func;
    assign seg_lcd_func_o = cur.seg_func;
    assign vpin_lcd_func_o = cur.vpin_func;
    assign port_input_enable_o = cur.port_in;
    assign res_chain_on_o = cur.res_on;
    assign res_high_value_o = cur.res_hi;
    assign bias_code_o = cur.bias;
    assign duty_o = cur.duty;
    assign frame_irq_flag_o = cur.irq_flag;
    assign frame_irq_o = cur.irq;
    assign running_o = cur.running;

    // ---------------------------------------------------------------
    // Checks.
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_halt_mode_off: assert property (
        (display_mode_field_i == MODE_OFF)[*2] |=> !running_o)
        else $error("controller runs with mode zero");
    chk_irq_gating: assert property (
        frame_irq_o |-> frame_irq_flag_o && $past(frame_irq_enable_i))
        else $error("request without flag or enable");
    chk_com_onehot: assert property (
        $onehot0(com_select_o))
        else $error("more than one common active");
    chk_four_com_ports: assert property (
        four_com |=> com_lcd_func_o[7:4] == 4'h0 || $changed(four_com))
        else $error("high commons in LCD use in four-common mode");
    chk_eight_seg_ports: assert property (
        !four_com && !$past(four_com) |-> seg_lcd_func_o[31:28] == 4'h0)
        else $error("upper segments in LCD use in eight-common mode");
    chk_polarity_flip: assert property (
        slot_tick && cur.st == ST_SCAN && run_ok && last_slot
        |=> cur.pol != $past(cur.pol))
        else $error("polarity did not alternate at frame end");
    chk_standby_halt: assert property (
        (stby_req && stby_type && !standby_run_enable_i)[*2] |=> !running_o)
        else $error("controller runs in standby");
    chk_blank_segs: assert property (
        slot_tick && cur.st == ST_SCAN && run_ok && blank_display_i
        |=> seg_level_o == {NUM_SEG{polarity_o}})
        else $error("blank display drives data");
    chk_flag_set: assert property (
        slot_tick && cur.st == ST_SCAN && run_ok && last_slot
        && frame_irq_enable_i |=> frame_irq_flag_o)
        else $error("frame flag not set");
    chk_res_chain: assert property (
        drive_source_select_i |=> res_chain_on_o)
        else $error("resistor chain not energised");
    cov_frame_end: cover property (frame_irq_flag_o && !$past(frame_irq_flag_o));
    cov_four_com: cover property (four_com && running_o);
    cov_standby: cover property (stby_req && stby_type && running_o);
    cov_blink: cover property ($changed(cur.blink_on));
endmodule : seg_lcd_ctrl

//--- hdl/seg_lcd_pkg.sv
package seg_lcd_pkg;
    localparam int        NUM_COM       = 8;
    localparam int        NUM_SEG       = 32;
    localparam int        RAM_BYTES     = 32;
    localparam int        SEG_8COM      = 28;
    localparam int        SEG_4COM      = 32;
    localparam int        BYTES_4COM    = 16;
    localparam logic [2:0] MODE_OFF     = 3'h0;
    // Display mode codes: 1..3 four-common at 1/2,1/3,1/4 duty, else 1/8.
    localparam logic [2:0] MODE_4C_D2   = 3'h1;
    localparam logic [2:0] MODE_4C_D3   = 3'h2;
    localparam logic [2:0] MODE_4C_D4   = 3'h3;
    localparam logic [3:0] DUTY_2       = 4'h2;
    localparam logic [3:0] DUTY_3       = 4'h3;
    localparam logic [3:0] DUTY_4       = 4'h4;
    localparam logic [3:0] DUTY_8       = 4'h8;
    localparam int        FRAME_SEL_W   = 3;
    localparam int        PRESCALE_W    = 16;
    // Shift of the first frame rate tap; each selection doubles the period.
    localparam int        TAP_BASE      = 4;
    localparam int        BLINK_W       = 2;
    localparam int        BLINK_BASE    = 4;
    localparam logic [7:0] PIN_EN_RESET = 8'h3c;
    // Bit positions inside the pin enable one value.
    localparam int        PE_VE1        = 2;
    localparam int        PE_THIRD_DRV  = 4;
    localparam int        PE_VE4        = 5;
    localparam int        PE_BLSEL      = 6;
    localparam int        PE_PORT_IN    = 7;
    localparam logic      BIAS_8C_RESET = 1'b1;
    localparam logic      BLANK_RESET   = 1'b1;
endpackage : seg_lcd_pkg

//--- hdl/seg_lcd_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a level from outside the clock domain.
module seg_lcd_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    typedef struct packed {
        logic s1;
        logic s2;
    } state_s;
    state_s cur, nxt;
    always_comb begin
        nxt.s1 = d_i;
        nxt.s2 = cur.s1;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end
    assign q_o = cur.s2;
endmodule : seg_lcd_sync

//--- hdl/seg_lcd_tick.sv
`timescale 1ns/1ps
// Source-tick prescaler, held at zero while run is low, that emits one pulse per selected period.
module seg_lcd_tick #(
    parameter int W = 16,
    parameter int BASE = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         src_i,
    input  wire logic         run_i,
    input  wire logic [2:0]   sel_i,
    output logic              tick_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } state_s;
    state_s cur, nxt;
    logic [W-1:0] mask;
    always_comb begin
        nxt = cur;
        mask = (W'(1) << (BASE + int'(sel_i))) - W'(1);
        nxt.tick = 1'b0;
        if (!run_i) begin
            nxt.cnt = '0;
        end else if (src_i) begin
            nxt.cnt = cur.cnt + W'(1);
            nxt.tick = ((cur.cnt & mask) == mask);
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end
    assign tick_o = cur.tick;
endmodule : seg_lcd_tick

//--- verif/lcd_panel_model.sv
`timescale 1ns/1ps
// Passive glass: decodes what each common slot shows and watches the scan.
module lcd_panel_model (
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    input  wire logic [seg_lcd_pkg::NUM_COM-1:0] com_select_i,
    input  wire logic [seg_lcd_pkg::NUM_COM-1:0] com_level_i,
    input  wire logic [seg_lcd_pkg::NUM_SEG-1:0] seg_level_i,
    input  wire logic                            polarity_i,
    input  wire logic [3:0]                      duty_i
);
    import seg_lcd_pkg::*;
    logic [NUM_SEG-1:0] lit [NUM_COM];
    logic [NUM_COM-1:0] prev_com;
    logic [NUM_COM-1:0] want;
    logic               prev_pol;
    int                 frames;
    int                 order_err;
    int                 flips;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_com = '0;
            prev_pol = 1'b0;
            frames = 0;
            order_err = 0;
            flips = 0;
        end else begin
            for (int c = 0; c < NUM_COM; c++) begin
                if (com_select_i == (8'h01 << c)) begin
                    // A cell is on when segment and common differ.
                    lit[c] = seg_level_i ^ {NUM_SEG{com_level_i[c]}};
                end
            end
            if (polarity_i !== prev_pol) flips++;
            prev_pol = polarity_i;
            if (com_select_i != prev_com && com_select_i != '0) begin
                want = prev_com[int'(duty_i) - 1] ? 8'h01 : prev_com << 1;
                if (prev_com != '0 && com_select_i != want) order_err++;
                if (com_select_i == 8'h01) frames++;
                prev_com = com_select_i;
            end
        end
    end
endmodule : lcd_panel_model

//--- verif/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("FAIL %s exp %0h got %0h", n, e, g); end end
module tb;
    import seg_lcd_pkg::*;
    logic        clk_i = 0, rst_i = 1, clk_src = 0, run_en = 0, drv = 0;
    logic [2:0]  mode = 0, rate = 0;
    logic        div = 0, bias8 = 0, invert = 0, blk = 0, irq_en = 0;
    logic        irq_clr = 0, stby = 0, stype = 0, we = 0;
    logic        tb_on = 1, wt_on = 0, tb_tick = 0, wt_tick = 0;
    logic [7:0]  pin1 = 8'h3c, wdata = 0, com_en = 8'hff;
    logic [4:0]  addr = 0;
    logic [31:0] seg_en = 32'hffffffff, seg_lvl, seg_fn, blink = 0;
    logic [7:0]  com_sel, com_lvl, com_fn, shadow [32];
    logic [3:0]  vpin, duty;
    logic [1:0]  bias;
    logic        pol, res_on, res_hi, flag, irq, run, pin_in;
    logic [1:0]  tcnt = 0;
    int          error_cnt = 0, checks = 0;

    initial forever #25 clk_i = ~clk_i;
    always @(negedge clk_i) begin
        tcnt <= tcnt + 2'h1;
        tb_tick <= tb_on && tcnt == 2'h0;
        wt_tick <= wt_on && tcnt == 2'h2;
    end

    seg_lcd_ctrl seg_lcd_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
        .frame_clock_source_select_i(clk_src), .standby_run_enable_i(run_en),
        .drive_source_select_i(drv), .display_mode_field_i(mode),
        .frame_rate_select_i(rate), .divider_value_select_i(div),
        .eight_common_bias_select_i(bias8), .invert_display_i(invert),
        .blank_display_i(blk), .frame_irq_enable_i(irq_en),
        .frame_irq_clear_i(irq_clr), .lcd_pin_enable_one_i(pin1),
        .com_pin_enable_i(com_en), .seg_pin_enable_i(seg_en),
        .blink_enable_i(blink), .timebase_tick_i(tb_tick),
        .watch_tick_i(wt_tick), .standby_req_i(stby),
        .standby_type_bit_i(stype), .ram_we_i(we), .ram_addr_i(addr),
        .ram_wdata_i(wdata), .com_level_o(com_lvl), .com_select_o(com_sel),
        .seg_level_o(seg_lvl), .polarity_o(pol), .com_lcd_func_o(com_fn),
        .seg_lcd_func_o(seg_fn), .vpin_lcd_func_o(vpin),
        .port_input_enable_o(pin_in), .res_chain_on_o(res_on),
        .res_high_value_o(res_hi), .bias_code_o(bias), .duty_o(duty),
        .frame_irq_flag_o(flag), .frame_irq_o(irq), .running_o(run));

    lcd_panel_model lcd_panel_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .com_select_i(com_sel), .seg_level_i(seg_lvl), .polarity_i(pol),
        .duty_i(duty), .com_level_i(com_lvl));

    task automatic print_verdict;
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic wait_frames(input int n);
        int f0, k;
        f0 = lcd_panel_model_inst.frames;
        for (k = 0; k < 20000 && lcd_panel_model_inst.frames < f0 + n; k++)
            @(negedge clk_i);
        if (k == 20000) begin
            error_cnt++;
            print_verdict();
        end
    endtask : wait_frames

    task automatic t_modes;
        logic [3:0] ed;
        for (int m = 1; m < 8; m++) begin
            for (int b = 0; b < 2; b++) begin
                mode = m[2:0];
                bias8 = b[0];
                repeat (2) @(negedge clk_i);
                ed = m == 1 ? DUTY_2 : m == 2 ? DUTY_3 : m == 3 ? DUTY_4 : DUTY_8;
                `CHK("duty", ed, duty)
                `CHK("bias", m == 1 ? 2'h2 : (m > 3 && b == 1) ? 2'h0 : 2'h3, bias)
                `CHK("com_fn", m < 4 ? 8'h0f : 8'hff, com_fn)
                `CHK("seg_fn", m < 4 ? 32'hffffffff : 32'h0fffffff, seg_fn)
                `CHK("running", 1'b1, run)
            end
        end
        mode = MODE_OFF;
        repeat (2) @(negedge clk_i);
        `CHK("halted", 1'b0, run)
    endtask : t_modes

    task automatic t_scan(input logic [2:0] m, input logic i, input logic b,
                          input logic [7:0] seed);
        logic [31:0] e, mask;
        logic        four;
        int          o0;
        four = m < 4;
        mode = m;
        invert = i;
        blk = b;
        for (int a = 0; a < 32; a++) begin
            @(negedge clk_i);
            we = 1;
            addr = a[4:0];
            wdata = a[7:0] * 8'h25 + seed;
            shadow[a] = wdata;
        end
        @(negedge clk_i);
        we = 0;
        wait_frames(1);
        o0 = lcd_panel_model_inst.order_err;
        wait_frames(1);
        mask = four ? 32'hffffffff : 32'h0fffffff;
        for (int c = 0; c < (m == 1 ? 2 : m == 2 ? 3 : four ? 4 : 8); c++) begin
            for (int s = 0; s < 32; s++)
                e[s] = four ? shadow[s / 2][(s % 2) * 4 + c] : shadow[s][c];
            e = b ? 32'h0 : i ? ~e : e;
            `CHK("segments", e & mask, lcd_panel_model_inst.lit[c] & mask)
        end
        `CHK("scan order", o0, lcd_panel_model_inst.order_err)
        `CHK("ac drive", 1'b1, lcd_panel_model_inst.flips > 0)
    endtask : t_scan

    task automatic t_standby;
        mode = 3'h4;
        stby = 1;
        stype = 1;
        repeat (6) @(negedge clk_i);
        `CHK("stop halts", 1'b0, run)
        run_en = 1;
        repeat (6) @(negedge clk_i);
        `CHK("stop runs", 1'b1, run)
        run_en = 0;
        stype = 0;
        repeat (6) @(negedge clk_i);
        `CHK("sleep runs", 1'b1, run)
        stby = 0;
    endtask : t_standby

    task automatic t_irq;
        irq_en = 0;
        wait_frames(2);
        `CHK("flag off", 1'b0, flag)
        `CHK("irq off", 1'b0, irq)
        irq_en = 1;
        wait_frames(1);
        repeat (20) @(negedge clk_i);
        `CHK("flag set", 1'b1, flag)
        `CHK("irq set", 1'b1, irq)
        irq_clr = 1;
        @(negedge clk_i);
        irq_clr = 0;
        repeat (2) @(negedge clk_i);
        `CHK("flag clr", 1'b0, flag)
        `CHK("irq clr", 1'b0, irq)
        irq_en = 0;
    endtask : t_irq

    task automatic t_power;
        drv = 1;
        div = 1;
        pin1 = 8'h00;
        repeat (2) @(negedge clk_i);
        `CHK("chain on", 1'b1, res_on)
        `CHK("100k", 1'b1, res_hi)
        `CHK("top pin", 1'b1, vpin[3])
        drv = 0;
        div = 0;
        repeat (2) @(negedge clk_i);
        `CHK("chain off", 1'b0, res_on)
        `CHK("10k", 1'b0, res_hi)
        `CHK("vpins port", 4'h0, vpin)
        `CHK("port input off", 1'b0, pin_in)
        pin1 = 8'hbc;
        repeat (2) @(negedge clk_i);
        `CHK("vpins lcd", 4'hf, vpin)
        `CHK("port input on", 1'b1, pin_in)
    endtask : t_power

    task automatic t_clock;
        int f0, o0;
        mode = 3'h4;
        clk_src = 1;
        repeat (10) @(negedge clk_i);
        f0 = lcd_panel_model_inst.frames;
        repeat (1200) @(negedge clk_i);
        `CHK("no watch tick", f0, lcd_panel_model_inst.frames)
        wt_on = 1;
        o0 = lcd_panel_model_inst.order_err;
        wait_frames(2);
        `CHK("watch order", o0, lcd_panel_model_inst.order_err)
        clk_src = 0;
        wt_on = 0;
    endtask : t_clock

    task automatic t_rate;
        int f0, n;
        mode = 3'h4;
        for (int r = 0; r < 2; r++) begin
            rate = r[2:0];
            wait_frames(2);
            f0 = lcd_panel_model_inst.frames;
            for (n = 0; n < 5000 && lcd_panel_model_inst.frames == f0; n++)
                @(negedge clk_i);
            `CHK("frame period", 32 << (TAP_BASE + r), n)
        end
        rate = 3'h0;
    endtask : t_rate

    task automatic t_blink;
        int off_seen, on_seen;
        off_seen = 0;
        on_seen = 0;
        mode = 3'h4;
        blink = '1;
        pin1 = 8'h7c;
        for (int f = 0; f < 36; f++) begin
            wait_frames(1);
            if (lcd_panel_model_inst.lit[0] == '0) off_seen++;
            else on_seen++;
        end
        `CHK("blink off", 1'b1, off_seen > 0)
        `CHK("blink on", 1'b1, on_seen > 0)
        blink = '0;
        pin1 = 8'h3c;
    endtask : t_blink

    initial begin
        repeat (3) @(negedge clk_i);
        `CHK("rst vpin", 4'hf, vpin)
        `CHK("rst bias", 2'h3, bias)
        `CHK("rst duty", DUTY_8, duty)
        `CHK("rst run", 1'b0, run)
        rst_i = 0;
        @(negedge clk_i);
        t_modes();
        t_scan(3'h4, 0, 0, 8'h13);
        t_scan(3'h7, 0, 0, 8'h5a);
        t_scan(3'h4, 1, 0, 8'h07);
        t_scan(3'h4, 0, 1, 8'h07);
        t_scan(3'h1, 0, 0, 8'h3c);
        t_scan(3'h2, 0, 0, 8'h61);
        t_scan(3'h3, 0, 0, 8'h29);
        t_standby();
        t_irq();
        t_power();
        t_clock();
        t_rate();
        t_blink();
        print_verdict();
    end
endmodule : tb
